/* logic/dsp_pkg.sv */
package dsp_pkg;
  // operation codes issued by the pipeline
  typedef enum logic [4:0] {
    OP_NONE      = 5'h00,
    OP_BYTE_HALF = 5'h01,
    OP_PAIR_FRAC = 5'h02,
    OP_HALF_FRAC = 5'h03,
    OP_HALF_MAC  = 5'h04,
    OP_LOAD_IDX  = 5'h05,
    OP_CTRL_WR   = 5'h06,
    OP_CTRL_RD   = 5'h07,
    OP_EXTR_W    = 5'h08,
    OP_EXTP      = 5'h09,
    OP_SHIFT_ACC = 5'h0a,
    OP_FILL_ACC  = 5'h0b,
    OP_FRAC_DOT  = 5'h0c,
    OP_PROD_DIFF = 5'h0d,
    OP_BYTE_DOT  = 5'h0e,
    OP_WORD_MAC  = 5'h0f,
    OP_POS_BR    = 5'h10,
    OP_MODSTEP   = 5'h11,
    OP_INS_VAR   = 5'h12,
    OP_BIT_REV   = 5'h13
  } op_t;

  // load sizes
  localparam logic [1:0] LD_WORD = 2'h0;
  localparam logic [1:0] LD_HALF = 2'h1;
  localparam logic [1:0] LD_BYTE = 2'h2;

  // control register field layout and mask bit positions
  localparam int POS_LSB  = 0;   // 6 bits
  localparam int SCNT_LSB = 7;   // 6 bits
  localparam int C_BIT    = 13;
  localparam int OUF_LSB  = 16;  // 8 bits
  localparam int CC_LSB   = 24;  // 4 bits
  localparam int EFI_BIT  = 14;
  localparam int M_POS = 0, M_SCNT = 1, M_C = 2, M_OUF = 3, M_CC = 4, M_EFI = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [5:0]  POS_LIMIT  = 6'h20;   // branch threshold

  // saturation bounds
  localparam logic [31:0] MAX31 = 32'h7fff_ffff;
  localparam logic [31:0] MIN31 = 32'h8000_0000;
  localparam logic [15:0] MAX15 = 16'h7fff;
  localparam logic [15:0] MIN15 = 16'h8000;
  localparam logic [15:0] MAXU16 = 16'hffff;
  localparam logic [63:0] MAX63 = 64'h7fff_ffff_ffff_ffff;
  localparam logic [63:0] MIN63 = 64'h8000_0000_0000_0000;

  // one issued operation
  typedef struct packed {
    logic        valid;
    op_t         op;
    logic [1:0]  acc;     // accumulator number
    logic        left;    // left (high) half/bytes select
    logic        sub;     // subtracting form
    logic        sat;     // saturating/_sa form
    logic        rnd;     // rounding form
    logic        dec;     // decrementing extract
    logic [5:0]  imm;     // shift / size / mask
    logic [1:0]  ld_size;
    logic [31:0] rs;
    logic [31:0] rt;
    logic [31:0] rd_old;  // destination old value for insert
  } issue_t;

  // result back to the pipeline
  typedef struct packed {
    logic        valid;
    logic        wr_gpr;
    logic [31:0] data;
    logic        taken;
    logic        ld_req;
    logic [31:0] ld_addr;
  } result_t;
endpackage

/* logic/simd_dsp_mac_datapath.sv */
`timescale 1ns/1ps
// How it works
// - gpr multiplies also overwrite accumulator zero
// - byte-by-half multiply, unsigned 16-bit saturated
// - paired q15 multiply, rounded and saturated
// - single-half q15 to q31, saturate minus-one squared
// - half-select mac into q32.31 accumulator
// - satacc variant saturates sum to q31
// - indexed loads: word, signed half, unsigned byte
// - masked control write by six mask bits
// - masked control read zeroes unselected fields
// - word extract at bit 0..31, round, saturate
// - positional extract, pos is field msb
// - decrementing extract sets pos below field
// - accumulator shift -32..+31, right logical
// - fill moves low to high, loads low
// - q15 dot product saturated, add or subtract
// - product difference written, not accumulated
// - byte dot product added or subtracted
// - q31 mac saturate product and sum
// - branch taken when pos at least 32
// - circular index decrement or reload maximum
// - variable insert uses pos and size count
// - reverse low 16 bits, zero high half
// - step low 8 bits, max high 24
module simd_dsp_mac_datapath #(
  parameter int N_ACC = 4               // accumulator count
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire dsp_pkg::issue_t  issue,     // decoded operation
  input  wire logic             ld_valid,  // load data return
  input  wire logic [31:0]      ld_data,
  output logic                  res_valid,
  output logic                  res_wr_gpr,
  output logic [31:0]           res_data,
  output logic                  res_taken,
  output logic                  ld_req,
  output logic [31:0]           ld_addr,
  output logic [31:0]           ctrl_out,  // control register view
  output logic [63:0]           acc0_out   // legacy high/low pair
);

  // whole module state
  typedef struct packed {
    logic [N_ACC-1:0][63:0] acc;
    logic [31:0]            ctrl;
    logic [1:0]             ld_size;
    logic                   ld_wait;
    dsp_pkg::result_t       res;
  } state_t;

  state_t s_q, s_d;

  // signed q15 x q15 to q31, only -1*-1 overflows
  function automatic logic [31:0] qmul(input logic [15:0] a, input logic [15:0] b);
    logic [31:0] p;
    p = 32'($signed(a) * $signed(b)) << 1;
    if (a == dsp_pkg::MIN15 && b == dsp_pkg::MIN15) p = dsp_pkg::MAX31;
    return p;
  endfunction

  // saturate a 64-bit signed value to q31
  function automatic logic [31:0] sat31(input logic [63:0] v);
    if ($signed(v) > $signed(64'(signed'(dsp_pkg::MAX31)))) return dsp_pkg::MAX31;
    if ($signed(v) < $signed({{32{1'b1}}, dsp_pkg::MIN31})) return dsp_pkg::MIN31;
    return v[31:0];
  endfunction

  // 64-bit add with signed saturation
  function automatic logic [63:0] sadd64(input logic [63:0] a, input logic [63:0] b);
    logic [63:0] r;
    r = a + b;
    if (a[63] == b[63] && r[63] != a[63]) r = a[63] ? dsp_pkg::MIN63 : dsp_pkg::MAX63;
    return r;
  endfunction

  // mask of width n bits (n 0..32)
  function automatic logic [31:0] lowmask(input logic [5:0] n);
    return (n >= 6'd32) ? 32'hffff_ffff : ((32'h1 << n) - 32'h1);
  endfunction

  // field mask of the control register for each mask bit
  function automatic logic [31:0] ctrl_mask(input logic [5:0] m);
    logic [31:0] f;
    f = 32'h0;
    if (m[dsp_pkg::M_POS])  f[dsp_pkg::POS_LSB +: 6]  = 6'h3f;
    if (m[dsp_pkg::M_SCNT]) f[dsp_pkg::SCNT_LSB +: 6] = 6'h3f;
    if (m[dsp_pkg::M_C])    f[dsp_pkg::C_BIT]         = 1'b1;
    if (m[dsp_pkg::M_OUF])  f[dsp_pkg::OUF_LSB +: 8]  = 8'hff;
    if (m[dsp_pkg::M_CC])   f[dsp_pkg::CC_LSB +: 4]   = 4'hf;
    if (m[dsp_pkg::M_EFI])  f[dsp_pkg::EFI_BIT]       = 1'b1;
    return f;
  endfunction

  // next state; one operation completes per cycle, loads answer later
  always_comb begin
    logic [63:0] a;
    logic [63:0] prod;
    logic [31:0] p1;
    logic [31:0] p0;
    logic [23:0] u1;  // wide enough for a full byte times halfword product
    logic [23:0] u0;
    logic [5:0]  pos;
    logic [5:0]  len;
    logic [5:0]  shamt;
    logic [63:0] t;
    logic [31:0] w;
    s_d = s_q;
    s_d.res.valid  = 1'b0;
    s_d.res.wr_gpr = 1'b0;
    s_d.res.taken  = 1'b0;
    s_d.res.ld_req = 1'b0;
    a     = s_q.acc[issue.acc];
    prod  = 64'h0;
    p1    = 32'h0;
    p0    = 32'h0;
    u1    = 24'h0;
    u0    = 24'h0;
    pos   = s_q.ctrl[dsp_pkg::POS_LSB +: 6];
    len   = 6'h0;
    shamt = issue.imm;
    t     = 64'h0;
    w     = 32'h0;
    // returning load data is extended by size
    if (s_q.ld_wait && ld_valid) begin
      s_d.ld_wait    = 1'b0;
      s_d.res.valid  = 1'b1;
      s_d.res.wr_gpr = 1'b1;
      case (s_q.ld_size)
        dsp_pkg::LD_HALF: s_d.res.data = {{16{ld_data[15]}}, ld_data[15:0]};
        dsp_pkg::LD_BYTE: s_d.res.data = {24'h0, ld_data[7:0]};
        default:          s_d.res.data = ld_data;
      endcase
    end
    if (issue.valid) begin
      s_d.res.valid = 1'b1;
      case (issue.op)
        dsp_pkg::OP_BYTE_HALF: begin
          u1 = 24'((issue.left ? issue.rs[31:24] : issue.rs[15:8]) * issue.rt[31:16]);
          u0 = 24'((issue.left ? issue.rs[23:16] : issue.rs[7:0]) * issue.rt[15:0]);
          // products wider than 16 bits clamp to all ones
          w = {(|u1[23:16]) ? dsp_pkg::MAXU16 : u1[15:0],
               (|u0[23:16]) ? dsp_pkg::MAXU16 : u0[15:0]};
          s_d.res.wr_gpr = 1'b1;
          s_d.res.data   = w;
          s_d.acc[0]     = {32'h0, w};
        end
        dsp_pkg::OP_PAIR_FRAC: begin
          p1 = qmul(issue.rs[31:16], issue.rt[31:16]);
          p0 = qmul(issue.rs[15:0], issue.rt[15:0]);
          // round at bit 15; max31 plus half would wrap, so clamp
          w[31:16] = (p1 >= 32'h7fff_8000 && !p1[31]) ? dsp_pkg::MAX15 : 16'((p1 + 32'h8000) >> 16);
          w[15:0]  = (p0 >= 32'h7fff_8000 && !p0[31]) ? dsp_pkg::MAX15 : 16'((p0 + 32'h8000) >> 16);
          s_d.res.wr_gpr = 1'b1;
          s_d.res.data   = w;
          s_d.acc[0]     = {32'h0, w};
        end
        dsp_pkg::OP_HALF_FRAC: begin
          w = issue.left ? qmul(issue.rs[31:16], issue.rt[31:16])
                         : qmul(issue.rs[15:0], issue.rt[15:0]);
          s_d.res.wr_gpr = 1'b1;
          s_d.res.data   = w;
          s_d.acc[0]     = {32'h0, w};
        end
        dsp_pkg::OP_HALF_MAC: begin
          p1 = issue.left ? qmul(issue.rs[31:16], issue.rt[31:16])
                          : qmul(issue.rs[15:0], issue.rt[15:0]);
          t  = a + {{32{p1[31]}}, p1};
          // sign of the high half must follow the clamped word, not the raw sum
          w = sat31(t);
          if (issue.sat) t = {{32{w[31]}}, w};
          s_d.acc[issue.acc] = t;
        end
        dsp_pkg::OP_LOAD_IDX: begin
          // address alignment is the issuer's duty, no check here
          s_d.res.valid   = 1'b0;
          s_d.res.ld_req  = 1'b1;
          s_d.res.ld_addr = issue.rs + issue.rt;
          s_d.ld_size     = issue.ld_size;
          s_d.ld_wait     = 1'b1;
        end
        dsp_pkg::OP_CTRL_WR: begin
          w = ctrl_mask(issue.imm);
          s_d.ctrl = (s_q.ctrl & ~w) | (issue.rs & w);
        end
        dsp_pkg::OP_CTRL_RD: begin
          s_d.res.wr_gpr = 1'b1;
          s_d.res.data   = s_q.ctrl & ctrl_mask(issue.imm);
        end
        dsp_pkg::OP_EXTR_W: begin
          shamt = issue.imm[4:0] == 5'h0 ? 6'h0 : {1'b0, issue.imm[4:0]};
          t = 64'($signed(a) >>> shamt);
          // rounding adds the bit just below the kept field
          if (issue.rnd && shamt != 6'h0) t = t + 64'(a[shamt - 6'h1]);
          s_d.res.wr_gpr = 1'b1;
          s_d.res.data   = issue.sat ? sat31(t) : t[31:0];
        end
        dsp_pkg::OP_EXTP: begin
          len = (issue.imm[4:0] == 5'h0) ? 6'h1 : {1'b0, issue.imm[4:0]} + 6'h1;
          // field ends at pos; fail flag when pos below size
          // seven bits so that pos 63 plus one does not wrap to zero
          if ({1'b0, pos} + 7'h1 < {1'b0, len}) begin
            s_d.ctrl[dsp_pkg::EFI_BIT] = 1'b1;
          end else begin
            s_d.ctrl[dsp_pkg::EFI_BIT] = 1'b0;
            t = a >> (pos + 6'h1 - len);
            s_d.res.data = t[31:0] & lowmask(len);
            if (issue.dec) s_d.ctrl[dsp_pkg::POS_LSB +: 6] = pos - len;
          end
          s_d.res.wr_gpr = 1'b1;
        end
        dsp_pkg::OP_SHIFT_ACC: begin
          // signed amount; negative means left shift
          if (shamt[5]) s_d.acc[issue.acc] = a << (6'h0 - shamt);
          else          s_d.acc[issue.acc] = a >> shamt;
        end
        dsp_pkg::OP_FILL_ACC: begin
          s_d.acc[issue.acc] = {a[31:0], issue.rs};
        end
        dsp_pkg::OP_FRAC_DOT: begin
          t = 64'($signed(qmul(issue.rs[31:16], issue.rt[31:16])))
            + 64'($signed(qmul(issue.rs[15:0], issue.rt[15:0])));
          w = sat31(t);
          s_d.acc[issue.acc] = issue.sub ? a - {{32{w[31]}}, w} : a + {{32{w[31]}}, w};
        end
        dsp_pkg::OP_PROD_DIFF: begin
          t = 64'($signed(qmul(issue.rs[31:16], issue.rt[31:16])))
            - 64'($signed(qmul(issue.rs[15:0], issue.rt[15:0])));
          s_d.acc[issue.acc] = t;
        end
        dsp_pkg::OP_BYTE_DOT: begin
          u1 = 24'(issue.left ? issue.rs[31:24] * issue.rt[31:24] : issue.rs[15:8] * issue.rt[15:8]);
          u0 = 24'(issue.left ? issue.rs[23:16] * issue.rt[23:16] : issue.rs[7:0] * issue.rt[7:0]);
          t  = 64'(u1) + 64'(u0);
          s_d.acc[issue.acc] = issue.sub ? a - t : a + t;
        end
        dsp_pkg::OP_WORD_MAC: begin
          if (issue.rs == dsp_pkg::MIN31 && issue.rt == dsp_pkg::MIN31) prod = dsp_pkg::MAX63;
          else prod = 64'($signed(issue.rs) * $signed(issue.rt)) << 1;
          if (issue.sub) begin
            // negating min63 would wrap; treat as adding max63 plus one
            s_d.acc[issue.acc] = (prod == dsp_pkg::MIN63) ? sadd64(sadd64(a, dsp_pkg::MAX63), 64'h1)
                                                          : sadd64(a, 64'h0 - prod);
          end else begin
            s_d.acc[issue.acc] = sadd64(a, prod);
          end
        end
        dsp_pkg::OP_POS_BR: begin
          s_d.res.taken = (pos >= dsp_pkg::POS_LIMIT);
        end
        dsp_pkg::OP_MODSTEP: begin
          s_d.res.wr_gpr = 1'b1;
          s_d.res.data = (issue.rs == 32'h0) ? {8'h0, issue.rt[31:8]}
                                              : issue.rs - {24'h0, issue.rt[7:0]};
        end
        dsp_pkg::OP_INS_VAR: begin
          len = s_q.ctrl[dsp_pkg::SCNT_LSB +: 6];
          w   = lowmask(len) << pos[4:0];
          s_d.res.wr_gpr = 1'b1;
          s_d.res.data = (issue.rd_old & ~w) | ((issue.rs << pos[4:0]) & w);
        end
        dsp_pkg::OP_BIT_REV: begin
          for (int i = 0; i < 16; i++) w[i] = issue.rt[15 - i];
          s_d.res.wr_gpr = 1'b1;
          s_d.res.data = {16'h0, w[15:0]};
        end
        default: begin
          s_d.res.valid = 1'b0;
        end
      endcase
    end
  end

  // register the whole state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.ctrl <= dsp_pkg::CTRL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops
  assign res_valid  = s_q.res.valid;
  assign res_wr_gpr = s_q.res.wr_gpr;
  assign res_data   = s_q.res.data;
  assign res_taken  = s_q.res.taken;
  assign ld_req     = s_q.res.ld_req;
  assign ld_addr    = s_q.res.ld_addr;
  assign ctrl_out   = s_q.ctrl;
  assign acc0_out   = s_q.acc[0];

endmodule // simd_dsp_mac_datapath

/* test/dsp_mem_model.sv */
`timescale 1ns/1ps
// memory behind indexed loads: answers one request after lat cycles
module dsp_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        ld_req,
  input  wire logic [31:0] ld_addr,
  input  wire logic [3:0]  lat,
  output logic             ld_valid,
  output logic [31:0]      ld_data
);
  logic [3:0]  cnt;   // cycles left before the answer
  logic [31:0] word;  // word of the pending load
  // data toggles while idle so nothing can live off a stale word
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt      <= 4'h0;
      ld_valid <= 1'b0;
      ld_data  <= 32'h0;
    end else begin
      ld_valid <= 1'b0;
      ld_data  <= ~ld_data;
      if (ld_req) begin
        word <= ld_addr ^ 32'h5a5a_a5a5;
        cnt  <= lat;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
        if (cnt == 4'h1) begin  // whole word, caller picks low bits
          ld_valid <= 1'b1;
          ld_data  <= word;
        end
      end
    end
  end
endmodule  // dsp_mem_model

/* test/simd_dsp_mac_datapath_asserts.sv */
`timescale 1ns/1ps
// port-level checker: each checked op's result is tied to the issue one cycle earlier; load data returns are not checked
module dsp_checker (
  input wire logic            ref_clk,
  input wire logic            rst,
  input wire dsp_pkg::issue_t issue,
  input wire logic            ld_valid,
  input wire logic [31:0]     ld_data,
  input wire logic            res_valid,
  input wire logic            res_wr_gpr,
  input wire logic [31:0]     res_data,
  input wire logic            res_taken,
  input wire logic            ld_req,
  input wire logic [31:0]     ld_addr,
  input wire logic [31:0]     ctrl_out,
  input wire logic [63:0]     acc0_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_bit_rev;
    issue.valid && issue.op == dsp_pkg::OP_BIT_REV |=>
      res_wr_gpr && res_data[31:16] == 16'h0 && res_data[15] == $past(issue.rt[0]);
  endproperty
  a_bit_rev: assert property (p_bit_rev)
    else $error("bit reverse result wrong");
  property p_ld_addr;
    issue.valid && issue.op == dsp_pkg::OP_LOAD_IDX |=>
      ld_req && ld_addr == $past(issue.rs) + $past(issue.rt);
  endproperty
  a_ld_addr: assert property (p_ld_addr)
    else $error("load address is not base plus index");
  property p_pos_br;
    issue.valid && issue.op == dsp_pkg::OP_POS_BR |=>
      res_valid && res_taken == ($past(ctrl_out[5:0]) >= 6'h20);
  endproperty
  a_pos_br: assert property (p_pos_br)
    else $error("position branch decision wrong");
  property p_fill;
    issue.valid && issue.op == dsp_pkg::OP_FILL_ACC && issue.acc == 2'h0 |=>
      acc0_out == {$past(acc0_out[31:0]), $past(issue.rs)};
  endproperty
  a_fill: assert property (p_fill)
    else $error("accumulator fill wrong");
  property p_gpr_mul;
    issue.valid && issue.op == dsp_pkg::OP_HALF_FRAC |=> acc0_out == {32'h0, res_data};
  endproperty
  a_gpr_mul: assert property (p_gpr_mul)
    else $error("gpr multiply did not land in accumulator zero");
  property p_sat_q31;
    issue.valid && issue.op == dsp_pkg::OP_HALF_FRAC && issue.left &&
      issue.rs[31:16] == 16'h8000 && issue.rt[31:16] == 16'h8000 |=>
      res_data == dsp_pkg::MAX31;
  endproperty
  a_sat_q31: assert property (p_sat_q31)
    else $error("minus one squared not saturated");
  property p_mask_none;
    issue.valid && issue.op == dsp_pkg::OP_CTRL_WR && issue.imm == 6'h0 |=> $stable(ctrl_out);
  endproperty
  a_mask_none: assert property (p_mask_none)
    else $error("control changed under empty mask");
  property p_ctrl_rd;
    issue.valid && issue.op == dsp_pkg::OP_CTRL_RD && issue.imm == 6'h01 |=>
      res_wr_gpr && res_data == {26'h0, $past(ctrl_out[5:0])};
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd)
    else $error("masked control read wrong");
  property p_shift_r;
    issue.valid && issue.op == dsp_pkg::OP_SHIFT_ACC && issue.acc == 2'h0 && !issue.imm[5] |=>
      acc0_out == $past(acc0_out) >> $past(issue.imm);
  endproperty
  a_shift_r: assert property (p_shift_r)
    else $error("accumulator right shift wrong");
  property p_modstep;
    issue.valid && issue.op == dsp_pkg::OP_MODSTEP && issue.rs == 32'h0 |=>
      res_data == {8'h0, $past(issue.rt[31:8])};
  endproperty
  a_modstep: assert property (p_modstep)
    else $error("index reload wrong");
  c_taken: cover property (res_taken);
  c_load: cover property (ld_valid ##1 res_valid);
  c_sat63: cover property (acc0_out == dsp_pkg::MAX63);
endmodule  // dsp_checker

/* test/test_simd_dsp_mac_datapath.sv */
`timescale 1ns/1ps
module test_simd_dsp_mac_datapath;
  logic            ref_clk, rst, ld_valid, res_valid, res_wr_gpr, res_taken, ld_req;
  dsp_pkg::issue_t issue;
  logic [31:0]     ld_data, res_data, ld_addr, ctrl_out;
  logic [63:0]     acc0_out;
  logic [3:0]      lat;         // memory answer delay
  int              num_errors, cmp_count, i;
  // one field per mask bit: pos, scount, carry, ouflag, ccond, efi
  logic [31:0]     fld [6] = '{32'h3f, 32'h1f80, 32'h2000, 32'hff_0000, 32'hf00_0000, 32'h4000};
  simd_dsp_mac_datapath simd_dsp_mac_datapath_inst (.ref_clk, .rst, .issue, .ld_valid,
    .ld_data, .res_valid, .res_wr_gpr, .res_data, .res_taken, .ld_req, .ld_addr,
    .ctrl_out, .acc0_out);
  dsp_mem_model dsp_mem_model_inst (.ref_clk, .rst, .ld_req, .ld_addr, .lat, .ld_valid,
    .ld_data);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // issue at a falling edge, leave valid up so calls chain back to back
  task automatic fire(input dsp_pkg::op_t op, input logic [31:0] rs, input logic [31:0] rt,
                      input logic [5:0] imm, input logic [4:0] fl);
    issue.valid = 1'b1;
    issue.op = op;
    issue.rs = rs;
    issue.rt = rt;
    issue.imm = imm;
    {issue.left, issue.sub, issue.sat, issue.rnd, issue.dec} = fl;
    @(negedge ref_clk);
  endtask
  task automatic idle();
    issue.valid = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic fill2(input logic [31:0] hi, input logic [31:0] lo);
    fire(dsp_pkg::OP_FILL_ACC, hi, 32'h0, 6'h0, 5'h0);
    fire(dsp_pkg::OP_FILL_ACC, lo, 32'h0, 6'h0, 5'h0);
    chk("fill", acc0_out, {hi, lo});
  endtask
  // aligned addresses only, split as base plus index
  task automatic load(input logic [1:0] sz, input logic [31:0] a, input logic [31:0] exp);
    issue.ld_size = sz;
    fire(dsp_pkg::OP_LOAD_IDX, 32'h100, a - 32'h100, 6'h0, 5'h0);
    chk("ld_addr", ld_addr, a);
    idle();
    for (int n = 0; n < 20 && res_valid !== 1'b1; n++) @(negedge ref_clk);
    chk("load data", res_data, exp);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // cuts a hang short well past the expected hundred or so cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    num_errors++;
    end_sim();
  end
  initial begin
    issue = '0;
    lat = 4'h1;
    rst = 1'b1;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    fire(dsp_pkg::OP_BYTE_HALF, 32'hff02_0310, 32'h0102_1234, 6'h0, 5'h10);
    chk("byte_half_l", res_data, 32'hffff_2468);
    chk("acc0 shadow", acc0_out, 64'hffff_2468);
    fire(dsp_pkg::OP_BYTE_HALF, 32'hff02_0310, 32'h0102_1234, 6'h0, 5'h0);
    chk("byte_half_r", res_data, 32'h0306_ffff);
    fire(dsp_pkg::OP_BYTE_HALF, 32'hff00_0000, 32'hffff_0000, 6'h0, 5'h10);
    chk("byte_half_big", res_data, 32'hffff_0000);
    fire(dsp_pkg::OP_PAIR_FRAC, 32'h8000_4000, 32'h8000_4000, 6'h0, 5'h0);
    chk("pair_frac", res_data, 32'h7fff_2000);
    fire(dsp_pkg::OP_HALF_FRAC, 32'h8000_4000, 32'h8000_c000, 6'h0, 5'h10);
    chk("half_frac_l", res_data, 32'h7fff_ffff);
    fire(dsp_pkg::OP_HALF_FRAC, 32'h8000_4000, 32'h8000_c000, 6'h0, 5'h0);
    chk("half_frac_r", res_data, 32'he000_0000);
    $display("test multiply done");
    fill2(32'h0, 32'h7fff_fff0);
    fire(dsp_pkg::OP_HALF_MAC, 32'h4000_0000, 32'h4000_0000, 6'h0, 5'h10);
    chk("mac", acc0_out, 64'h9fff_fff0);
    fill2(32'h0, 32'h7fff_fff0);
    fire(dsp_pkg::OP_HALF_MAC, 32'h4000_0000, 32'h4000_0000, 6'h0, 5'h14);
    chk("mac sat", acc0_out, 64'h7fff_ffff);
    fill2(32'h0, 32'h0);
    fire(dsp_pkg::OP_FRAC_DOT, 32'h8000_8000, 32'h8000_8000, 6'h0, 5'h04);
    chk("dot add", acc0_out, 64'h7fff_ffff);
    fire(dsp_pkg::OP_PROD_DIFF, 32'h4000_2000, 32'h4000_4000, 6'h0, 5'h04);
    chk("prod diff", acc0_out, 64'h1000_0000);
    fire(dsp_pkg::OP_FRAC_DOT, 32'h8000_8000, 32'h8000_8000, 6'h0, 5'h0c);
    chk("dot sub", acc0_out, 64'hffff_ffff_9000_0001);
    fill2(32'h0, 32'h1000_0000);
    fire(dsp_pkg::OP_BYTE_DOT, 32'hff02_0102, 32'hff03_0304, 6'h0, 5'h10);
    chk("byte dot add", acc0_out, 64'h1000_fe07);
    fire(dsp_pkg::OP_BYTE_DOT, 32'hff02_0102, 32'hff03_0304, 6'h0, 5'h08);
    chk("byte dot sub", acc0_out, 64'h1000_fdfc);
    fire(dsp_pkg::OP_WORD_MAC, 32'h8000_0000, 32'h8000_0000, 6'h0, 5'h04);
    chk("word mac add", acc0_out, dsp_pkg::MAX63);
    fire(dsp_pkg::OP_WORD_MAC, 32'h4000_0000, 32'h4000_0000, 6'h0, 5'h0c);
    chk("word mac sub", acc0_out, 64'h5fff_ffff_ffff_ffff);
    $display("test accumulate done");
    fill2(32'h1234_5678, 32'h9abc_def0);
    fire(dsp_pkg::OP_SHIFT_ACC, 32'h0, 32'h0, 6'h04, 5'h0);
    chk("shift right", acc0_out, 64'h0123_4567_89ab_cdef);
    fire(dsp_pkg::OP_SHIFT_ACC, 32'h0, 32'h0, 6'h20, 5'h0);
    chk("shift left 32", acc0_out, 64'h89ab_cdef_0000_0000);
    fire(dsp_pkg::OP_EXTR_W, 32'h0, 32'h0, 6'h1f, 5'h0);
    chk("extract", res_data, 32'h1357_9bde);
    fire(dsp_pkg::OP_EXTR_W, 32'h0, 32'h0, 6'h1f, 5'h06);
    chk("extract sat", res_data, dsp_pkg::MIN31);
    $display("test extract done");
    for (i = 0; i < 6; i++) begin
      fire(dsp_pkg::OP_CTRL_WR, 32'h0, 32'h0, 6'h3f, 5'h0);
      fire(dsp_pkg::OP_CTRL_WR, 32'hffff_ffff, 32'h0, 6'(1 << i), 5'h0);
      chk("ctrl field", ctrl_out, fld[i]);
      fire(dsp_pkg::OP_CTRL_RD, 32'h0, 32'h0, 6'h3f ^ 6'(1 << i), 5'h0);
      chk("ctrl read off", res_data, 32'h0);
    end
    fire(dsp_pkg::OP_CTRL_WR, 32'hffff_ffff, 32'h0, 6'h3f, 5'h0);
    fire(dsp_pkg::OP_CTRL_WR, 32'h0, 32'h0, 6'h00, 5'h0);
    chk("ctrl all", ctrl_out, 32'h0fff_7fbf);
    fire(dsp_pkg::OP_CTRL_RD, 32'h0, 32'h0, 6'h22, 5'h0);
    chk("ctrl read", res_data, 32'h5f80);
    fire(dsp_pkg::OP_CTRL_RD, 32'h0, 32'h0, 6'h01, 5'h0);
    chk("pos read", res_data, 32'h3f);
    fire(dsp_pkg::OP_EXTP, 32'h0, 32'h0, 6'h07, 5'h01);
    chk("extp first", res_data, 32'h89);
    chk("pos after", ctrl_out[5:0], 6'd55);
    fire(dsp_pkg::OP_EXTP, 32'h0, 32'h0, 6'h07, 5'h01);
    chk("extp second", res_data, 32'hab);
    chk("pos after", ctrl_out[5:0], 6'd47);
    fire(dsp_pkg::OP_POS_BR, 32'h0, 32'h0, 6'h0, 5'h0);
    chk("branch 47", res_taken, 1'b1);
    for (i = 31; i < 33; i++) begin
      fire(dsp_pkg::OP_CTRL_WR, 32'(i), 32'h0, 6'h01, 5'h0);
      fire(dsp_pkg::OP_POS_BR, 32'h0, 32'h0, 6'h0, 5'h0);
      chk("branch", res_taken, i >= 32);
    end
    fire(dsp_pkg::OP_CTRL_WR, 32'h404, 32'h0, 6'h03, 5'h0);
    issue.rd_old = 32'hffff_ffff;
    fire(dsp_pkg::OP_INS_VAR, 32'ha5, 32'h0, 6'h0, 5'h0);
    chk("insert", res_data, 32'hffff_fa5f);
    fire(dsp_pkg::OP_MODSTEP, 32'h0, 32'h6403, 6'h0, 5'h0);
    chk("index reload", res_data, 32'h64);
    fire(dsp_pkg::OP_MODSTEP, 32'h10, 32'h6403, 6'h0, 5'h0);
    chk("index step", res_data, 32'hd);
    fire(dsp_pkg::OP_BIT_REV, 32'h0, 32'hffff_1235, 6'h0, 5'h0);
    chk("bit reverse", res_data, 32'h0000_ac48);
    idle();
    $display("test control done");
    load(dsp_pkg::LD_WORD, 32'h120, 32'h5a5a_a485);
    lat = 4'h5;
    load(dsp_pkg::LD_HALF, 32'h122, 32'hffff_a487);
    load(dsp_pkg::LD_BYTE, 32'h123, 32'h86);
    $display("test load done");
    end_sim();
  end
endmodule  // test_simd_dsp_mac_datapath
bind simd_dsp_mac_datapath dsp_checker dsp_checker_inst (.ref_clk, .rst, .issue, .ld_valid,
  .ld_data, .res_valid, .res_wr_gpr, .res_data, .res_taken, .ld_req, .ld_addr, .ctrl_out,
  .acc0_out);
